// ### rtl/hpbad_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module hpbad_bridge (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_offset,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   input  wire logic        host_cfg_rd,
   input  wire logic [7:0]  host_bus,
   input  wire logic [4:0]  host_dev,
   input  wire logic        host_lock,
   input  wire logic        host_shadow_bios,
   input  wire logic        address_parity_error_signal,
   output logic             claim_pci,
   output logic             claim_watchdog,
   output logic             lock_unsupported,
   output logic             aliased_mode,
   output logic             bus_error_signal
);
   // ----------------------------------------------------------------
   // behaviour overview
   // ----------------------------------------------------------------
   // three configuration registers live here: the extended error
   // command word, the sixteen-bit missing-device log and the decode
   // mode byte. every register write is taken on a rising edge with
   // the clock enable high and lands one cycle later. a read returns
   // the old value when a write to the same offset shares its cycle.
   //
   // host configuration reads on bus 0 to ids 16..31 are routed one
   // cycle after they are taken. a logged id is claimed and forwarded,
   // so the far side ends it with a master abort. an id whose bit is
   // clear still goes the slow watchdog way. that keeps software that
   // never fills the log working, at the price of the long time-out.
   //
   // software must leave the bits of present ids at zero; a wrongly
   // set bit sends live traffic to the master-abort path and loses it.
   // the block cannot tell a present id from an absent one by itself.
   //
   // the lock flag only reports a locked shadow access in aliased
   // mode; stopping or retrying the lock is left to the host side.
   // parity-to-bus-error conversion is registered, so the bus error
   // trails the parity error by one cycle.
   //
   // with the clock enable low every register, output included, holds.
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] err_cmd_r, err_cmd_nxt;
   logic [15:0] miss_log_r, miss_log_nxt;
   logic [7:0]  decode_r, decode_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        pci_r, pci_nxt, wd_r, wd_nxt;
   logic        lock_r, lock_nxt, bus_error_signal_r, bus_error_signal_nxt;
   typedef hpbad_pkg::hpbad_route_t hpbad_route_local_t;
   hpbad_route_local_t route;
   logic        in_range;
   logic [15:0] absent_sel;

   // byte-lane merge keeps unwritten lanes intact
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // configuration register access
   // ----------------------------------------------------------------
   always_comb begin
      err_cmd_nxt  = err_cmd_r;
      miss_log_nxt = miss_log_r;
      decode_nxt   = decode_r;
      rdata_nxt    = rdata_r;
      if (cfg_wr) begin
         case (cfg_offset)
            hpbad_pkg::OFS_EXT_ERR_CMD: begin
               err_cmd_nxt = merge(err_cmd_r, cfg_wdata, cfg_be);
            end
            hpbad_pkg::OFS_MISSING_LOG: begin
               miss_log_nxt = 16'(merge({16'h0000, miss_log_r},
                                        cfg_wdata, cfg_be));
            end
            hpbad_pkg::OFS_DECODE_MODE: begin
               decode_nxt = 8'(merge({24'h000000, decode_r},
                                     cfg_wdata, cfg_be));
            end
            default: ;
         endcase
      end
      if (cfg_rd) begin
         // unmapped offsets read as zero
         case (cfg_offset)
            hpbad_pkg::OFS_EXT_ERR_CMD: rdata_nxt = err_cmd_r;
            hpbad_pkg::OFS_MISSING_LOG: rdata_nxt = {16'h0000, miss_log_r};
            hpbad_pkg::OFS_DECODE_MODE: rdata_nxt = {24'h000000, decode_r};
            default:                    rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decode of host configuration reads and error conversion
   // ----------------------------------------------------------------
   always_comb begin
      // only IDs 16..31 on bus 0 are covered by the log
      in_range = (host_bus == hpbad_pkg::HOST_BUS_NUM) &&
                 host_dev[4];
      route    = hpbad_pkg::HPBAD_ROUTE_NONE;
      if (host_cfg_rd && in_range) begin
         if (|absent_sel) begin
            route = hpbad_pkg::HPBAD_ROUTE_PCI;
         end else begin
            route = hpbad_pkg::HPBAD_ROUTE_WATCHDOG;
         end
      end
      pci_nxt  = 1'b0;
      wd_nxt   = 1'b0;
      case (route)
         hpbad_pkg::HPBAD_ROUTE_PCI:      pci_nxt = 1'b1;
         hpbad_pkg::HPBAD_ROUTE_WATCHDOG: wd_nxt  = 1'b1;
         default: ;
      endcase
      // shadow locks unsupported while aliased; flag it to the host side
      lock_nxt = host_lock && host_shadow_bios &&
                 decode_r[hpbad_pkg::BIT_ALIASED];
      bus_error_signal_nxt = address_parity_error_signal &&
                 err_cmd_r[hpbad_pkg::BIT_ERR_CONVERT];
   end

   // ----------------------------------------------------------------
   // per-id absent lookup
   // ----------------------------------------------------------------
   // one select per log bit; bit k answers for host id k plus 16, so
   // ids below 16 never match and need no separate guard here
   for (genvar k = 0; k < 16; k++) begin : g_absent
      assign absent_sel[k] = miss_log_r[k] &&
                             (host_dev == 5'(k + 16));
   end

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the lookup above assumes a sixteen-entry log based at id 16
   if ($bits(hpbad_pkg::RST_MISSING_LOG) != 16) begin : g_bad_width
      $error("missing-device log must be sixteen bits wide");
   end
   if (hpbad_pkg::DEV_LOG_BASE != 5'h10) begin : g_bad_base
      $error("missing-device log must start at host id 16");
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_cmd_r  <= hpbad_pkg::RST_EXT_ERR_CMD;
         miss_log_r <= hpbad_pkg::RST_MISSING_LOG;
         decode_r   <= hpbad_pkg::RST_DECODE_MODE;
         rdata_r    <= 32'h0000_0000;
         pci_r      <= 1'b0;
         wd_r       <= 1'b0;
         lock_r     <= 1'b0;
         bus_error_signal_r     <= 1'b0;
      end else if (clk_en) begin
         err_cmd_r  <= err_cmd_nxt;
         miss_log_r <= miss_log_nxt;
         decode_r   <= decode_nxt;
         rdata_r    <= rdata_nxt;
         pci_r      <= pci_nxt;
         wd_r       <= wd_nxt;
         lock_r     <= lock_nxt;
         bus_error_signal_r     <= bus_error_signal_nxt;
      end
   end

   assign cfg_rdata        = rdata_r;
   assign claim_pci        = pci_r;
   assign claim_watchdog   = wd_r;
   assign lock_unsupported = lock_r;
   assign aliased_mode     = decode_r[hpbad_pkg::BIT_ALIASED];
   assign bus_error_signal = bus_error_signal_r;
endmodule
`default_nettype wire

// ### common/hpbad_pkg.sv
package hpbad_pkg;
   // ----------------------------------------------------------------
   // configuration offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_DECODE_MODE = 8'h48;
   localparam logic [7:0]  OFS_EXT_ERR_CMD = 8'hC0;
   localparam logic [7:0]  OFS_MISSING_LOG = 8'hCC;
   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_EXT_ERR_CMD = 32'h0000_0010;
   localparam logic [15:0] RST_MISSING_LOG = 16'h0000;
   localparam logic [7:0]  RST_DECODE_MODE = 8'h06;
   localparam int          BIT_ERR_CONVERT = 1;
   localparam int          BIT_ALIASED     = 3;
   localparam logic [4:0]  DEV_LOG_BASE    = 5'h10;
   localparam logic [7:0]  HOST_BUS_NUM    = 8'h00;
   // claim routing for a host-bus configuration read
   typedef enum logic [1:0] {
      HPBAD_ROUTE_NONE,
      HPBAD_ROUTE_PCI,
      HPBAD_ROUTE_WATCHDOG
   } hpbad_route_t;
endpackage

// ### test/hpbad_bridge_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hpbad_bridge_check (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        cfg_wr,
   input wire logic        host_cfg_rd,
   input wire logic [7:0]  host_bus,
   input wire logic [4:0]  host_dev,
   input wire logic        address_parity_error_signal,
   input wire logic        claim_pci,
   input wire logic        claim_watchdog,
   input wire logic        lock_unsupported,
   input wire logic        aliased_mode,
   input wire logic        bus_error_signal
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // reads the log governs: bus 0, ids 16 to 31
   wire logic hit = host_cfg_rd && host_bus == 8'h00 && host_dev[4];
   // a frozen edge keeps old flags, so causes are looked for on live ones
   property p_pci; claim_pci && $past(clk_en) |-> $past(hit); endproperty
   a_pci: assert property (p_pci) else $error("pci claim");
   property p_wdg; claim_watchdog && $past(clk_en) |-> $past(hit);
   endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog");
   property p_one; hit && clk_en |=> claim_pci ^ claim_watchdog; endproperty
   a_one: assert property (p_one) else $error("no claim");
   property p_off;
      host_cfg_rd && !hit && clk_en |=> !(claim_pci | claim_watchdog);
   endproperty
   a_off: assert property (p_off) else $error("off window");
   property p_two; !(claim_pci && claim_watchdog); endproperty
   a_two: assert property (p_two) else $error("two claims");
   property p_err;
      bus_error_signal && $past(clk_en) |-> $past(address_parity_error_signal);
   endproperty
   a_err: assert property (p_err) else $error("bus error");
   property p_lck; lock_unsupported && $past(clk_en) |-> $past(aliased_mode);
   endproperty
   a_lck: assert property (p_lck) else $error("lock flag");
   property p_als;
      $changed(aliased_mode) |-> $past(cfg_wr) && $past(clk_en);
   endproperty
   a_als: assert property (p_als) else $error("mode");
   property p_frz;
      !clk_en |=> $stable(claim_pci) && $stable(claim_watchdog) &&
                  $stable(bus_error_signal) && $stable(aliased_mode);
   endproperty
   a_frz: assert property (p_frz) else $error("freeze");
   c_pci: cover property (claim_pci);
   c_lck: cover property (lock_unsupported);
   c_wdg: cover property (claim_watchdog);
   c_err: cover property (bus_error_signal);
endmodule
bind hpbad_bridge hpbad_bridge_check i_chk (.*);
`default_nettype wire

// ### test/hpbad_pci_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpbad_pci_model #(parameter logic [15:0] POP = 16'h5A3C) (
   input wire logic [4:0] dev,
   output logic [31:0] id
);
   // absent slots master-abort and read all ones; present id is arbitrary
   assign id = POP[dev[3:0]] ? 32'h1234_5678 : 32'hFFFF_FFFF;
endmodule
`default_nettype wire

// ### test/hpbad_bridge_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hpbad_bridge_bench;
   logic clk = 1'h0, rst = 1'h1, clk_en = 1'h1, host_shadow_bios = 1'h1;
   logic cfg_wr = 1'h0, cfg_rd = 1'h0, host_cfg_rd = 1'h0, host_lock = 1'h0;
   logic address_parity_error_signal = 1'h0, claim_pci, claim_watchdog;
   logic lock_unsupported, aliased_mode, bus_error_signal;
   logic [7:0] cfg_offset = '0, host_bus = '0;
   logic [4:0] host_dev = '0, sdev = '0;
   logic [3:0] cfg_be = 4'hF;
   logic [31:0] cfg_wdata = '0, cfg_rdata, pid;
   logic [15:0] log_v = '0;
   int bad_count = 0, cmp_count = 0;
   hpbad_bridge i_dut (.*);
   hpbad_pci_model i_pci (.dev(sdev), .id(pid));
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) bad_count++;
      if (g !== e) $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
   endtask
   // one register cycle; a read is compared against d
   task automatic cfg(input logic w, input logic [7:0] o, input logic [31:0] d);
      @(posedge clk) {cfg_wr, cfg_rd, cfg_offset, cfg_wdata} <= {w, !w, o, d};
      @(posedge clk) {cfg_wr, cfg_rd} <= 2'h0;
      #1 if (!w) chk(cfg_rdata, d);
   endtask
   // claims land one cycle after the request edge
   task automatic hr(input logic [7:0] b, input logic [4:0] d);
      @(posedge clk) {host_cfg_rd, host_bus, host_dev} <= {1'h1, b, d};
      @(posedge clk) host_cfg_rd <= 1'h0;
      #1 chk(32'({claim_pci, claim_watchdog}), 32'(exp_claim(b, d)));
   endtask
   function automatic logic [1:0] exp_claim(logic [7:0] b, logic [4:0] d);
      return (b == 8'h00 && d[4]) ? (log_v[d[3:0]] ? 2'h2 : 2'h1) : 2'h0;
   endfunction
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(24702));
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      cfg(1'h0, 8'hC0, 32'h0000_0010);
      cfg(1'h0, 8'hCC, 32'h0);
      cfg(1'h0, 8'h50, 32'h0);
      hr(8'h00, 5'h1F);
      // bus 0 scan: an all-ones id marks the slot absent
      for (int d = 0; d < 16; d++) begin
         sdev = 5'(d + 16);
         #1 log_v[d] = (pid === 32'hFFFF_FFFF);
      end
      cfg(1'h1, 8'hCC, {16'h0, log_v});
      cfg(1'h0, 8'hCC, {16'h0, log_v});
      repeat (80) hr(8'($urandom % 2), 5'($urandom));
      // lane 0 only: the upper log byte must survive
      @(posedge clk) cfg_be <= 4'h1;
      cfg(1'h1, 8'hCC, 32'hFFFF_FFFF);
      @(posedge clk) cfg_be <= 4'hF;
      cfg(1'h0, 8'hCC, {16'h0, log_v[15:8], 8'hFF});
      cfg(1'h1, 8'hCC, {16'h0, log_v});
      // frozen clock enable: a request must leave no claim behind
      @(posedge clk) {clk_en, host_cfg_rd, host_dev} <= {2'h1, 5'h10};
      @(posedge clk) {clk_en, host_cfg_rd} <= 2'h2;
      #1 chk(32'({claim_pci, claim_watchdog}), 32'h0);
      for (int k = 0; k < 2; k++) begin
         cfg(1'h1, 8'hC0, 32'h10 | 32'(k << 1));
         cfg(1'h1, 8'h48, 32'h06 | 32'(k << 3));
         @(posedge clk) {address_parity_error_signal, host_lock} <= 2'h3;
         hr(8'h01, 5'h10);
         chk(32'({aliased_mode, lock_unsupported, bus_error_signal}),
            32'(k * 7));
         @(posedge clk) {address_parity_error_signal, host_lock} <= 2'h0;
      end
      // aliased mode on: locked shadow access flags, remapped one not
      @(posedge clk) host_lock <= 1'h1;
      @(posedge clk) host_shadow_bios <= 1'h0;
      #1 chk(32'(lock_unsupported), 32'h1);
      @(posedge clk) host_lock <= 1'h0;
      #1 chk(32'(lock_unsupported), 32'h0);
      // reset in mid-run returns the error command word, the log and the aliased bit to their defaults
      @(posedge clk) {rst, host_shadow_bios} <= 2'h3;
      @(posedge clk) rst <= 1'h0;
      #1 chk(32'(aliased_mode), 32'h0);
      cfg(1'h0, 8'hC0, 32'h0000_0010);
      cfg(1'h0, 8'hCC, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
